// >>> rtl/ifsp_pkg.sv
package ifsp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned LINK_MAX_BPS = 12_000_000;
  // Wake/flush strobe must stay low this long to count (ns)
  localparam int unsigned STROBE_MIN_NS = 50;
  localparam int unsigned STROBE_MIN_CYC =
      (STROBE_MIN_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS = 8;
  localparam logic [3:0] BIT_CNT_LAST = 4'h7;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam logic [3:0] STROBE_CNT_RST = 4'h0;
  localparam logic [3:0] STROBE_CNT_MAX = 4'(STROBE_MIN_CYC);
  typedef enum logic [1:0] {IFSP_IDLE, IFSP_SHIFT, IFSP_DONE} ifsp_tx_state_t;
endpackage

// >>> rtl/ifsp_port.sv
// Behaviour
// - Link uses exactly four wires: data in, data out, clock in, clear-to-send.
// - Data enters on its input pin, leaves on its own output pin.
// - Clear-to-send driven low when ready to send, high otherwise.
// - Suspended with remote wakeup enabled, low strobe requests USB resume.
// - Powered active, low strobe flushes pending receive data on next bulk IN.
// - Link logic tolerates the peripheral clocking at up to 12 Mbps.
`timescale 1ns/1ps
`default_nettype none
module ifsp_port
  import ifsp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Isolated link pins
  input wire logic iso_serial_in,
  input wire logic iso_link_clock,
  output logic iso_serial_out,
  output logic iso_clear_to_send_n,
  // Wake and power state
  input wire logic flush_wake_n,
  input wire logic powered_active_n,
  input wire logic remote_wake_en,
  output logic resume_req,
  output logic flush_req,
  // Transmit buffer side (toward the link)
  input wire logic [ifsp_pkg::WORD_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Receive buffer side (from the link)
  output logic [ifsp_pkg::WORD_BITS-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  import ifsp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic lclk_s;
  logic sdi_s;
  logic wake_s;
  logic pwr_s;
  ifsp_sync u_lclk (.clock(clock), .reset(reset), .async_in(iso_link_clock),
                    .reset_value(1'b1), .sync_out(lclk_s));
  ifsp_sync u_sdi (.clock(clock), .reset(reset), .async_in(iso_serial_in),
                   .reset_value(1'b1), .sync_out(sdi_s));
  ifsp_sync u_wake (.clock(clock), .reset(reset), .async_in(flush_wake_n),
                    .reset_value(1'b1), .sync_out(wake_s));
  ifsp_sync u_pwr (.clock(clock), .reset(reset), .async_in(powered_active_n),
                   .reset_value(1'b1), .sync_out(pwr_s));

  // ----------------------------------------------------------------
  // Link clock edge detection
  // ----------------------------------------------------------------
  logic lclk_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) lclk_q <= 1'b1;
    else lclk_q <= lclk_s;
  end
  wire rise = lclk_s & ~lclk_q;
  wire fall = ~lclk_s & lclk_q;

  // ----------------------------------------------------------------
  // Receive shifter: sample on rising edge
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] rx_sh_q;
  logic [3:0] rx_cnt_q;
  logic [WORD_BITS-1:0] rx_data_q;
  logic rx_valid_q;
  wire rx_word_done = rise & (rx_cnt_q == BIT_CNT_LAST);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_sh_q <= WORD_RST;
      rx_cnt_q <= BIT_CNT_RST;
    end else if (rise) begin
      rx_sh_q <= {sdi_s, rx_sh_q[WORD_BITS-1:1]};
      rx_cnt_q <= rx_word_done ? BIT_CNT_RST : rx_cnt_q + 4'h1;
    end
  end
  // Holding register; link pace is slow against clock so one word suffices
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_data_q <= WORD_RST;
      rx_valid_q <= 1'b0;
    end else if (rx_word_done) begin
      rx_data_q <= {sdi_s, rx_sh_q[WORD_BITS-1:1]};
      rx_valid_q <= 1'b1;
    end else if (rx_ready) begin
      rx_valid_q <= 1'b0;
    end
  end
  assign rx_data = rx_data_q;
  assign rx_valid = rx_valid_q;

  // ----------------------------------------------------------------
  // Transmit shifter: change on falling edge
  // ----------------------------------------------------------------
  ifsp_tx_state_t st_q;
  logic [WORD_BITS-1:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic sdo_q;
  logic cts_n_q;
  logic tx_ready_q;
  wire load = (st_q == IFSP_IDLE) & tx_valid & tx_ready_q;
  wire tx_last = fall & (tx_cnt_q == BIT_CNT_LAST);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= IFSP_IDLE;
      tx_sh_q <= WORD_RST;
      tx_cnt_q <= BIT_CNT_RST;
      sdo_q <= 1'b1;
      cts_n_q <= 1'b1;
      tx_ready_q <= 1'b0;
    end else begin
      unique case (st_q)
        IFSP_IDLE: begin
          tx_ready_q <= ~load;
          cts_n_q <= 1'b1;
          if (load) begin
            tx_sh_q <= tx_data;
            tx_cnt_q <= BIT_CNT_RST;
            cts_n_q <= 1'b0;
            st_q <= IFSP_SHIFT;
          end
        end
        IFSP_SHIFT: begin
          // Peripheral may stall; state only moves on its edges
          if (fall) begin
            sdo_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[WORD_BITS-1:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_last) st_q <= IFSP_DONE;
          end
        end
        IFSP_DONE: begin
          cts_n_q <= 1'b1;
          st_q <= IFSP_IDLE;
        end
        default: st_q <= IFSP_IDLE;
      endcase
    end
  end
  assign iso_serial_out = sdo_q;
  assign iso_clear_to_send_n = cts_n_q;
  assign tx_ready = tx_ready_q;

  // ----------------------------------------------------------------
  // Wake / flush strobe
  // ----------------------------------------------------------------
  logic [3:0] stb_cnt_q;
  logic resume_q;
  logic flush_q;
  wire stb_hit = ~wake_s & (stb_cnt_q == STROBE_CNT_MAX - 4'h1);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) stb_cnt_q <= STROBE_CNT_RST;
    else if (wake_s) stb_cnt_q <= STROBE_CNT_RST;
    else if (stb_cnt_q != STROBE_CNT_MAX) stb_cnt_q <= stb_cnt_q + 4'h1;
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      resume_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      resume_q <= stb_hit & pwr_s & remote_wake_en;
      flush_q <= stb_hit & ~pwr_s;
    end
  end
  assign resume_req = resume_q;
  assign flush_req = flush_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Strobe seen high, then held low long enough to count
  sequence s_strobe;
    wake_s ##1 !wake_s [*5];
  endsequence
  property p_cts_idle;
    @(posedge clock) disable iff (reset) (st_q == IFSP_IDLE) && !load |=> iso_clear_to_send_n;
  endproperty
  a_cts_idle: assert property (p_cts_idle) else $error("cts low while idle");
  property p_cts_load;
    @(posedge clock) disable iff (reset) load |=> !iso_clear_to_send_n;
  endproperty
  a_cts_load: assert property (p_cts_load) else $error("cts not low on load");
  property p_sdo_fall;
    @(posedge clock) disable iff (reset) !fall && st_q != IFSP_IDLE |=> $stable(iso_serial_out);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("data out moved off edge");
  property p_rx_count;
    @(posedge clock) disable iff (reset) !rise |=> $stable(rx_cnt_q);
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("rx moved off edge");
  property p_resume;
    @(posedge clock) disable iff (reset) resume_req |-> $past(pwr_s) && $past(remote_wake_en);
  endproperty
  a_resume: assert property (p_resume) else $error("resume outside suspend");
  property p_resume_fire;
    @(posedge clock) disable iff (reset) s_strobe ##0 (pwr_s && remote_wake_en) |=> resume_req;
  endproperty
  a_resume_fire: assert property (p_resume_fire) else $error("strobe gave no resume");
  property p_flush;
    @(posedge clock) disable iff (reset) s_strobe ##0 !pwr_s |=> flush_req;
  endproperty
  a_flush: assert property (p_flush) else $error("strobe gave no flush");
  property p_flush_src;
    @(posedge clock) disable iff (reset) flush_req |-> !$past(pwr_s) && !$past(wake_s);
  endproperty
  a_flush_src: assert property (p_flush_src) else $error("flush without strobe");
  property p_rx_valid;
    @(posedge clock) disable iff (reset) rx_word_done |=> rx_valid;
  endproperty
  a_rx_valid: assert property (p_rx_valid) else $error("word lost");
  property p_no_both;
    @(posedge clock) disable iff (reset) !(resume_req && flush_req);
  endproperty
  a_no_both: assert property (p_no_both) else $error("resume and flush together");
endmodule // ifsp_port
`default_nettype wire

// >>> rtl/ifsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ifsp_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  input wire logic reset_value,
  output logic sync_out
);
  logic meta_q;
  logic sync_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  // Reset value strap only steers the output while held in reset
  assign sync_out = sync_q & (reset_value | ~reset);
endmodule // ifsp_sync
`default_nettype wire

// >>> test/ifsp_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ifsp_peer (
  // Link pins seen from the peripheral
  output logic link_clock,
  output logic to_dev,
  input wire logic from_dev
);
  initial begin
    link_clock = 1'b1;
    to_dev = 1'b1;
  end
  // One word each way; the clock stands high between words
  task automatic xfer(input logic [7:0] ow, output logic [7:0] iw, input realtime hp, st);
    for (int i = 0; i < 8; i++) begin
      link_clock = 1'b0;
      to_dev = ow[i];
      #(hp);
      link_clock = 1'b1;
      iw[i] = from_dev;
      #(hp);
      if (i == 3) #(st);
    end
    to_dev = ~ow[7];
  endtask
endmodule // ifsp_peer
`default_nettype wire

// >>> test/isolated_fast_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module isolated_fast_serial_port_tb;
  import ifsp_pkg::*;
  logic clock, reset, flush_wake_n, powered_active_n, remote_wake_en, tx_valid, rx_ready;
  logic [7:0] tx_data;
  wire logic lclk, sdi, sdo, cts_n, resume_req, flush_req, tx_ready, rx_valid;
  wire logic [7:0] rx_data;
  int errors, n_checks;
  ifsp_port u_dut (.clock(clock), .reset(reset), .iso_serial_in(sdi), .iso_link_clock(lclk),
    .iso_serial_out(sdo), .iso_clear_to_send_n(cts_n), .flush_wake_n(flush_wake_n),
    .powered_active_n(powered_active_n), .remote_wake_en(remote_wake_en),
    .resume_req(resume_req), .flush_req(flush_req), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
  ifsp_peer u_peer (.link_clock(lclk), .to_dev(sdi), .from_dev(sdo));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send_word(input logic [7:0] d);
    int k;
    tx_data = d;
    tx_valid = 1'b1;
    for (k = 0; k < 50; k++) begin
      if (tx_ready === 1'b1) begin
        @(posedge clock);
        break;
      end
      @(posedge clock);
      #1;
    end
    if (k == 50) begin
      errors++;
      test_done();
    end
    #1;
    tx_valid = 1'b0;
  endtask
  task automatic t_word(input logic [7:0] tw, rw, input realtime hp, st);
    logic [7:0] got;
    int k;
    send_word(tw);
    @(posedge clock);
    #1;
    chk("cts_n busy", 8'h00, cts_n);
    chk("tx_ready busy", 8'h00, tx_ready);
    u_peer.xfer(rw, got, hp, st);
    chk("word on link", tw, got);
    for (k = 0; k < 50 && rx_valid !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    if (k == 50) begin
      errors++;
      test_done();
    end
    chk("rx_data", rw, rx_data);
    #1;
    rx_ready = 1'b1;
    @(posedge clock);
    #1;
    rx_ready = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk("rx_valid", 8'h00, rx_valid);
    chk("cts_n idle", 8'h01, cts_n);
    chk("tx_ready idle", 8'h01, tx_ready);
  endtask
  task automatic t_wake(input logic pa_n, en, input int len, input logic [7:0] nr, nf);
    logic [7:0] cr, cf;
    cr = 8'h00;
    cf = 8'h00;
    powered_active_n = pa_n;
    remote_wake_en = en;
    repeat (4) @(posedge clock);
    #1;
    flush_wake_n = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      #1;
      if (i == len) flush_wake_n = 1'b1;
      cr += resume_req;
      cf += flush_req;
    end
    chk("resume pulses", nr, cr);
    chk("flush pulses", nf, cf);
  endtask
  initial begin
    reset = 1'b1;
    flush_wake_n = 1'b1;
    powered_active_n = 1'b0;
    remote_wake_en = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b0;
    repeat (8) @(posedge clock);
    chk("sdo reset", 8'h01, sdo);
    chk("cts_n reset", 8'h01, cts_n);
    #1;
    reset = 1'b0;
    t_word(8'hA5, 8'h3C, 62.5, 0);
    t_word(8'h81, 8'h7E, 400, 3000);
    t_word(8'h00, 8'hFF, 62.5, 0);
    t_wake(1'b1, 1'b1, 8, 8'h01, 8'h00);
    t_wake(1'b0, 1'b1, 8, 8'h00, 8'h01);
    t_wake(1'b1, 1'b0, 8, 8'h00, 8'h00);
    t_wake(1'b0, 1'b0, 2, 8'h00, 8'h00);
    test_done();
  end
endmodule // isolated_fast_serial_port_tb
`default_nettype wire
